// ---- hdl/ssp_spi_port.v ----
// Purpose: SPI-mode half of a synchronous serial port, master or slave
// Assumes: sck and ssN come from another clock domain and are synchronised
// Notes:   the oscillator is modelled by clk; one bit time at /4 is 4 clk
`timescale 1ns/10ps
`include "ssp_spi_consts.vh"
module ssp_spi_port (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       portEnable,
  input  wire       clockPolarity,
  input  wire       clockEdgeSelect,
  input  wire       samplePhase,
  input  wire [3:0] modeSelect,
  input  wire       portAPinTwoLatch,
  input  wire       timerTick,
  input  wire       sdoDirOutput,
  input  wire       wrValid,
  input  wire [7:0] wrData,
  output wire       wrReady,
  input  wire       rdStrobe,
  output reg  [7:0] dataBuffer,
  output wire       rxValid,
  input  wire       rxReady,
  output reg  [7:0] rxData,
  output reg        bufferFullFlag,
  output reg        portInterruptFlag,
  input  wire       intFlagClear,
  output reg        writeCollisionFlag,
  input  wire       collisionClear,
  output reg        receiveOverflowFlag,
  input  wire       overflowClear,
  output reg        wakeRequest,
  output reg        busy,
  input  wire       sckIn,
  output reg        sckOut,
  output wire       sckOe,
  input  wire       sdiIn,
  output reg        sdoOut,
  output wire       sdoOe,
  input  wire       ssN
);

  // Bus-side decode of the mode field
  wire isMaster  = (modeSelect <= `SSP_MODE_MTMR);
  wire ssCtl     = (modeSelect == `SSP_MODE_SLV_SS) && portAPinTwoLatch;
  wire isSlave   = ~isMaster;

  // Two-flop synchronisers for the pins from the far side
  reg [1:0] sckSync_q;
  reg [1:0] sdiSync_q;
  reg [1:0] ssSync_q;
  reg       sckPrev_q;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sckSync_q <= 2'h0;
      sdiSync_q <= 2'h0;
      ssSync_q  <= 2'h3;
      sckPrev_q <= 1'b0;
    end
    else
    begin
      sckSync_q <= {sckSync_q[0], sckIn};
      sdiSync_q <= {sdiSync_q[0], sdiIn};
      ssSync_q  <= {ssSync_q[0], ssN};
      sckPrev_q <= sckSync_q[1];
    end
  end
  wire sckS = sckSync_q[1];
  wire sdiS = sdiSync_q[1];
  wire ssHigh = ssSync_q[1];

  // Port held in reset while disabled or deselected
  wire portClear = ~portEnable | (ssCtl & ssHigh);

  // Select high floats SDO straight from the pin so no byte boundary waits
  assign sdoOe = portEnable & sdoDirOutput & ~(ssCtl & ssN);
  assign sckOe = portEnable & isMaster;

  // Slave edges on synchronised SCK: leading is away from idle level
  wire sckRise = sckS & ~sckPrev_q;
  wire sckFall = ~sckS & sckPrev_q;
  wire slvLead  = clockPolarity ? sckFall : sckRise;
  wire slvTrail = clockPolarity ? sckRise : sckFall;

  // Two-entry transmit buffer between software writes and the shifter
  reg [7:0] txMem [0:`SSP_BUF_DEPTH-1];
  reg       txWr_q;
  reg       txRd_q;
  reg [1:0] txCnt_q;
  wire      txValid = (txCnt_q != 2'h0);
  wire      txFull  = (txCnt_q == 2'h2);
  reg       txPop;
  // Collision: a write while shifting is discarded, not queued
  wire      wrAttempt = wrValid & ~txFull;
  wire      wrBlocked = wrValid & (busy | ~portEnable);
  wire      txPush    = wrAttempt & ~wrBlocked;
  assign    wrReady = ~txFull;

  // Buffer pointers and occupancy
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txWr_q  <= 1'b0;
      txRd_q  <= 1'b0;
      txCnt_q <= 2'h0;
    end
    else
    begin
      if (txPush)
      begin
        txMem[txWr_q] <= wrData;
        txWr_q        <= ~txWr_q;
      end
      if (txPop)
        txRd_q <= ~txRd_q;
      case ({txPush, txPop})
        2'b10:   txCnt_q <= txCnt_q + 2'h1;
        2'b01:   txCnt_q <= txCnt_q - 2'h1;
        default: txCnt_q <= txCnt_q;
      endcase
    end
  end

  // Master rate: reload value, one less than the half-period in clk ticks, or timer based
  function [5:0] halfLen;
    input [3:0] mode;
    begin
      case (mode)
        `SSP_MODE_M4:  halfLen = `SSP_DIV4_HALF;
        `SSP_MODE_M16: halfLen = `SSP_DIV16_HALF;
        default:       halfLen = `SSP_DIV64_HALF;
      endcase
    end
  endfunction

  // Shift engine state
  reg [7:0] shift_q;
  reg [3:0] bitCnt_q;
  reg [5:0] divCnt_q;
  reg [4:0] edgeCnt_q;
  reg       sampPend_q;
  // First tick whose sample is kept: edge select and sample phase pick it
  wire [4:0] sampFirst = clockEdgeSelect ? {4'h0, samplePhase} : (samplePhase ? 5'h02 : 5'h01);
  reg       rxDone;
  reg [7:0] rxByte;
  reg       tmrHalf_q;
  wire      tick = (modeSelect == `SSP_MODE_MTMR) ? (timerTick & tmrHalf_q)
                                                  : (divCnt_q == 6'h00);

  // Timer output is halved by taking every second pulse
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tmrHalf_q <= 1'b0;
    else if (timerTick)
      tmrHalf_q <= ~tmrHalf_q;
  end

  // Master drives SCK; slave follows external edges; both shift MSb first
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_q  <= 8'h00;
      bitCnt_q <= 4'h0;
      divCnt_q <= 6'h00;
      edgeCnt_q  <= 5'h00;
      sampPend_q <= 1'b0;
      busy     <= 1'b0;
      sckOut   <= 1'b0;
      sdoOut   <= 1'b0;
      txPop    <= 1'b0;
      rxDone   <= 1'b0;
      rxByte   <= 8'h00;
    end
    else
    begin
      txPop  <= 1'b0;
      rxDone <= 1'b0;
      sampPend_q <= 1'b0;
      if (portClear)
      begin
        bitCnt_q <= 4'h0;
        busy     <= 1'b0;
        edgeCnt_q <= 5'h00;
        sckOut   <= clockPolarity;
        if (isSlave & txValid & ~txPop)
        begin
          shift_q <= txMem[txRd_q];
          sdoOut  <= txMem[txRd_q][7];
          txPop   <= 1'b1;
        end
      end
      else if (isMaster)
      begin
        if (!busy)
        begin
          sckOut <= clockPolarity;
          if (txValid & ~txPop)
          begin
            shift_q  <= txMem[txRd_q];
            sdoOut   <= txMem[txRd_q][7];
            txPop    <= 1'b1;
            busy     <= 1'b1;
            bitCnt_q <= 4'h0;
            edgeCnt_q <= 5'h00;
            divCnt_q <= halfLen(modeSelect);
          end
        end
        else
        begin
          divCnt_q <= (divCnt_q == 6'h00) ? halfLen(modeSelect) : divCnt_q - 6'h01;
          // A sample lands one clk after its tick, so the two-flop delay on SDI is covered
          if (sampPend_q)
          begin
            rxByte   <= {rxByte[6:0], sdiS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          if (tick)
          begin
            edgeCnt_q  <= edgeCnt_q + 5'h01;
            sampPend_q <= (edgeCnt_q >= sampFirst) && (edgeCnt_q[0] == sampFirst[0])
                          && (bitCnt_q != `SSP_BITS);
            if (edgeCnt_q < 5'h10)
              sckOut <= ~sckOut;
            // Edge select 0 moves data on leading edges, 1 on trailing edges
            if (!clockEdgeSelect && !edgeCnt_q[0] && (edgeCnt_q < 5'h10))
            begin
              sdoOut  <= shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
            if (clockEdgeSelect && edgeCnt_q[0] && (edgeCnt_q < 5'h0f))
            begin
              sdoOut  <= shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          // Done once sixteen edges are out and eight samples are in
          if ((edgeCnt_q >= 5'h10) && (bitCnt_q == `SSP_BITS) && !sampPend_q)
          begin
            busy   <= 1'b0;
            rxDone <= 1'b1;
          end
        end
      end
      else
      begin
        // Slave: the first leading edge marks the transfer busy
        if (slvLead)
        begin
          busy <= 1'b1;
          if (clockEdgeSelect)
            shift_q <= {shift_q[6:0], sdiS};
          else
            sdoOut <= shift_q[7];
        end
        if (slvTrail)
        begin
          if (!clockEdgeSelect)
            shift_q <= {shift_q[6:0], sdiS};
          else
            sdoOut <= shift_q[7];
          bitCnt_q <= bitCnt_q + 4'h1;
          if (bitCnt_q == `SSP_BITS - 4'h1)
          begin
            bitCnt_q <= 4'h0;
            busy     <= 1'b0;
            rxDone   <= 1'b1;
            rxByte   <= clockEdgeSelect ? shift_q : {shift_q[6:0], sdiS};
          end
        end
        if (!busy & txValid & ~txPop & ~slvLead)
        begin
          shift_q <= txMem[txRd_q];
          sdoOut  <= txMem[txRd_q][7];
          txPop   <= 1'b1;
        end
      end
    end
  end

  // Received-byte stream mirrors the buffer for a streaming consumer
  reg rxValid_q;
  assign rxValid = rxValid_q;

  // Buffer, flags and wake; a set always beats a clear in the same cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dataBuffer          <= 8'h00;
      rxData              <= 8'h00;
      rxValid_q           <= 1'b0;
      bufferFullFlag      <= 1'b0;
      portInterruptFlag   <= 1'b0;
      writeCollisionFlag  <= 1'b0;
      receiveOverflowFlag <= 1'b0;
      wakeRequest         <= 1'b0;
    end
    else
    begin
      wakeRequest <= rxDone & isSlave;
      if (rxValid_q & rxReady)
        rxValid_q <= 1'b0;
      if (rxDone)
      begin
        portInterruptFlag <= 1'b1;
        if (bufferFullFlag & ~rdStrobe)
          receiveOverflowFlag <= 1'b1;
        else
        begin
          dataBuffer     <= rxByte;
          bufferFullFlag <= 1'b1;
          rxData         <= rxByte;
          rxValid_q      <= 1'b1;
        end
      end
      else
      begin
        if (rdStrobe)
          bufferFullFlag <= 1'b0;
        if (intFlagClear)
          portInterruptFlag <= 1'b0;
        if (overflowClear)
          receiveOverflowFlag <= 1'b0;
      end
      if (wrBlocked)
        writeCollisionFlag <= 1'b1;
      else if (collisionClear)
        writeCollisionFlag <= 1'b0;
    end
  end

endmodule // ssp_spi_port

// ---- hdl/ssp_spi_consts.vh ----
// Purpose: constants for the serial port module, SPI mode
// Assumes: 20 MHz system clock; control fields arrive as plain ports
// Notes:   mode codes share the four mode-select bits
`ifndef SSP_SPI_CONSTS_VH
`define SSP_SPI_CONSTS_VH
`define SSP_MODE_M4        4'h0
`define SSP_MODE_M16       4'h1
`define SSP_MODE_M64       4'h2
`define SSP_MODE_MTMR      4'h3
`define SSP_MODE_SLV_SS    4'h4
`define SSP_MODE_SLV       4'h5
`define SSP_DIV4_HALF      6'h01
`define SSP_DIV16_HALF     6'h07
`define SSP_DIV64_HALF     6'h1f
`define SSP_BITS           4'h8
`define SSP_BUF_DEPTH      2
`endif

// ---- tb/ssp_spi_port_props.sv ----
// Purpose: concurrent checks on the SPI port pins and flags
// Assumes: one clock domain, reset_n active low
// Notes:   sees only the top module ports
`timescale 1ns/10ps
module ssp_spi_port_props (
  input wire       clk,
  input wire       reset_n,
  input wire       portEnable,
  input wire       clockPolarity,
  input wire       clockEdgeSelect,
  input wire [3:0] modeSelect,
  input wire       wrValid,
  input wire [7:0] wrData,
  input wire       rdStrobe,
  input wire       busy,
  input wire       bufferFullFlag,
  input wire       portInterruptFlag,
  input wire       writeCollisionFlag,
  input wire       collisionClear,
  input wire       sckOut,
  input wire       sckOe,
  input wire       sdoOut,
  input wire       sdoOe,
  input wire       ssN
);
  reg  [7:0] lastWr_q;
  wire       master = portEnable && (modeSelect < 4'h4);
  // Byte handed to an idle port; its MSb must lead the frame
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      lastWr_q <= 8'h00;
    else if (wrValid && !busy)
      lastWr_q <= wrData;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  write_collision_flag_set_a: assert property (wrValid && busy |=> writeCollisionFlag)
    else $error("collision flag not set");
  write_collision_flag_hold_a: assert property (writeCollisionFlag && !collisionClear |=> writeCollisionFlag)
    else $error("collision flag lost");
  bf_clear_a: assert property (rdStrobe && !busy && !$past(busy) |=> !bufferFullFlag)
    else $error("buffer full not cleared");
  idle_sck_a: assert property (sckOe && $past(sckOe) && !busy && !$past(busy) && $past(reset_n)
    && $stable(clockPolarity) |-> sckOut == clockPolarity) else $error("sck not idle");
  sdo_float_a: assert property (portEnable && modeSelect == 4'h4 && ssN |-> !sdoOe)
    else $error("sdo driven while deselected");
  start_a: assert property (wrValid && !busy && master |-> ##2 busy)
    else $error("write did not start");
  flag_a: assert property ($fell(busy) && master && $past(master) |=> portInterruptFlag && bufferFullFlag)
    else $error("flags not set");
  cke_first_a: assert property ($rose(busy) && master && clockEdgeSelect
    |-> sdoOut == lastWr_q[7] && sckOut == clockPolarity) else $error("msb not ready");
endmodule // ssp_spi_port_props
bind ssp_spi_port ssp_spi_port_props props (.clk, .reset_n, .portEnable, .clockPolarity, .clockEdgeSelect,
  .modeSelect, .wrValid, .wrData, .rdStrobe, .busy, .bufferFullFlag, .portInterruptFlag, .writeCollisionFlag,
  .collisionClear, .sckOut, .sckOe, .sdoOut, .sdoOe, .ssN);

// ---- tb/ssp_spi_peer.sv ----
// Purpose: behavioural SPI slave facing the master port
// Assumes: selN low frames a byte; sck idles at cpol
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/10ps
module ssp_spi_peer (
  input wire       sck,
  input wire       sdo,
  input wire       cpol,
  input wire       cke,
  input wire       selN,
  input wire [7:0] txByte,
  output reg       sdi,
  output reg [7:0] rxByte
);
  reg [7:0] sh;
  initial sdi = 1'b0;
  initial rxByte = 8'h00;
  // With edge select set the MSb must stand before the first edge
  always @(negedge selN)
  begin
    sh = txByte;
    if (cke)
    begin
      sdi = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end
  // Released line must not keep its value, so late samples show up
  always @(posedge selN)
    sdi = ~sdi;
  // Sample on one edge, shift on the other
  always @(sck)
    if (!selN)
    begin
      if ((sck != cpol) == cke)
        rxByte = {rxByte[6:0], sdo};
      else
      begin
        sdi = sh[7];
        sh = {sh[6:0], 1'b0};
      end
    end
endmodule // ssp_spi_peer

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the SPI port, master and slave
// Assumes: 20 MHz clk, 400 ns link clock in slave frames
// Notes:   random bytes from a 16-bit shift register seeded 48337
`timescale 1ns/10ps
module tb;
  reg        clk = 1'b0, reset_n = 1'b0, portEnable = 1'b0, clockPolarity = 1'b0, clockEdgeSelect = 1'b0;
  reg        samplePhase = 1'b0, timerTick = 1'b0, sdoDirOutput = 1'b1, wrValid = 1'b0, rdStrobe = 1'b0;
  reg        rxReady = 1'b0, intFlagClear = 1'b0, collisionClear = 1'b0, sckIn = 1'b0, sdiTb = 1'b0;
  reg        ssN = 1'b1, peerSelN = 1'b1, slaveOn = 1'b0, wakeSeen = 1'b0;
  reg  [3:0] modeSelect = 4'h0;
  reg  [7:0] wrData = 8'h00, peerTx = 8'h00;
  reg  [1:0] tickCnt = 2'h0;
  reg [15:0] seed;
  wire [7:0] dataBuffer, rxData, peerRx;
  wire       wrReady, rxValid, bufferFullFlag, portInterruptFlag, writeCollisionFlag;
  wire       wakeRequest, busy, sckOut, sckOe, sdoOut, sdoOe, peerSdi;
  integer    nFail = 0, testsRun = 0, k;
  reg  [7:0] expQ[$];
  ssp_spi_port uut (.clk, .reset_n, .portEnable, .clockPolarity, .clockEdgeSelect, .samplePhase, .modeSelect,
    .portAPinTwoLatch(1'b1), .timerTick, .sdoDirOutput, .wrValid, .wrData, .wrReady, .rdStrobe, .dataBuffer,
    .rxValid, .rxReady, .rxData, .bufferFullFlag, .portInterruptFlag, .intFlagClear, .writeCollisionFlag,
    .collisionClear, .receiveOverflowFlag(), .overflowClear(1'b0), .wakeRequest, .busy, .sckIn, .sckOut,
    .sckOe, .sdiIn(slaveOn ? sdiTb : peerSdi), .sdoOut, .sdoOe, .ssN);
  ssp_spi_peer peer (.sck(sckOut), .sdo(sdoOut), .cpol(clockPolarity), .cke(clockEdgeSelect),
    .selN(peerSelN), .txByte(peerTx), .sdi(peerSdi), .rxByte(peerRx));
  always #25 clk = ~clk;
  // Timer output every third clock gives the timer rate its own length
  always @(posedge clk)
  begin
    tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
    timerTick <= (tickCnt == 2'h2);
    if (rxValid === 1'b1 && rxReady)
      chk("rxData", rxData, expQ.pop_front());
    if (wakeRequest === 1'b1)
      wakeSeen <= 1'b1;
  end
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function integer expPer(input [3:0] m);
    expPer = (m == 4'h3) ? 12 : 4 << (2 * m);
  endfunction
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    testsRun = testsRun + 1;
    if (seen !== exp)
    begin
      nFail = nFail + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task testDone;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // Disable before changing the set-up, then enable again
  task cfg(input [3:0] m, input [2:0] r);
    portEnable = 1'b0;
    tick(1);
    modeSelect = m;
    {clockPolarity, clockEdgeSelect, samplePhase} = r;
    sckIn = r[2];
    slaveOn = m[2];
    // Let the synchronised link clock settle while the port is still off
    tick(4);
    portEnable = 1'b1;
    tick(2);
  endtask
  // Master frame; col drops a second write into the running transfer
  task mXfer(input [7:0] d, input [7:0] pd, input col);
    integer n, e0, e1;
    reg prev;
    e0 = 0;
    e1 = 0;
    prev = clockPolarity;
    peerTx = pd;
    peerSelN = 1'b0;
    expQ.push_back(pd);
    wrData = d;
    wrValid = 1'b1;
    for (n = 1; n < 3000 && !(n > 3 && busy === 1'b0); n = n + 1)
    begin
      tick(1);
      wrValid = col && n == 5;
      wrData = ~d;
      if (sckOut !== prev && sckOut !== clockPolarity)
      begin
        e1 = (e0 != 0 && e1 == 0) ? n : e1;
        e0 = (e0 == 0) ? n : e0;
      end
      prev = sckOut;
    end
    if (n >= 3000)
    begin
      nFail = nFail + 1;
      testDone;
    end
    tick(2);
    peerSelN = 1'b1;
    chk("period", e1 - e0, expPer(modeSelect));
    if (sdoDirOutput) chk("peerRx", peerRx, d);
    else chk("sdoOe", sdoOe, 1'b0);
    chk("dataBuffer", dataBuffer, pd);
    chk("flags", {bufferFullFlag, portInterruptFlag, writeCollisionFlag}, {2'b11, col});
    chk("sckIdle", sckOut, clockPolarity);
    rdStrobe = 1'b1;
    intFlagClear = 1'b1;
    collisionClear = 1'b1;
    tick(1);
    {rdStrobe, intFlagClear, collisionClear} = 3'b000;
    tick(1);
    chk("cleared", {bufferFullFlag, portInterruptFlag, writeCollisionFlag}, 3'b000);
  endtask
  // Slave frame; the link clock moves only inside the frame
  task sXfer(input [7:0] d, input integer nb);
    integer i;
    for (i = 7; i > 7 - nb; i = i - 1)
    begin
      sdiTb = d[i];
      #100 sckIn = ~clockPolarity;
      #200 sckIn = clockPolarity;
      #100;
    end
    sdiTb = ~sdiTb;
  endtask
  initial
  begin
    seed = 16'hbcd1;
    tick(10);
    reset_n = 1'b1;
    tick(2);
    for (k = 0; k < 8; k = k + 1)
    begin
      seed = lfsr(seed);
      rxReady = (k != 0);
      sdoDirOutput = (k != 5);
      cfg(k[3:0] & 4'h3, seed[2:0]);
      mXfer(seed[15:8], seed[10:3] ^ 8'h5a, k[0]);
    end
    seed = lfsr(seed);
    cfg(4'h5, seed[2:0] & 3'b101);
    wakeSeen = 1'b0;
    expQ.push_back(seed[15:8]);
    sXfer(seed[15:8], 8);
    tick(8);
    chk("slaveByte", dataBuffer, seed[15:8]);
    chk("wake", wakeSeen, 1'b1);
    rdStrobe = 1'b1;
    tick(1);
    rdStrobe = 1'b0;
    cfg(4'h4, seed[2:0]);
    ssN = 1'b0;
    sXfer(seed[7:0], 4);
    ssN = 1'b1;
    #1 chk("sdoFloat", sdoOe, 1'b0);
    tick(2);
    ssN = 1'b0;
    expQ.push_back(seed[11:4]);
    sXfer(seed[11:4], 8);
    tick(8);
    chk("afterAbort", dataBuffer, seed[11:4]);
    ssN = 1'b1;
    cfg(4'h2, 3'b000);
    wrData = seed[7:0];
    wrValid = 1'b1;
    tick(1);
    wrValid = 1'b0;
    tick(40);
    reset_n = 1'b0;
    tick(1);
    chk("resetAbort", {busy, sckOut, portInterruptFlag}, 3'b000);
    reset_n = 1'b1;
    tick(40);
    chk("drained", expQ.size(), 0);
    testDone;
  end
endmodule // tb
